// *** src/bie_pkg.sv ***
// Shared constants and types for the basic instruction execute block.
// Assumes a 24-bit one's complement word and a 15-bit program address.
package bie_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and key count
  localparam int WORD_W = 24;
  localparam int ADDR_W = 15;
  localparam int CHAR_W = 6;
  localparam int KEY_COUNT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int OP_LSB = 18;
  localparam int AFLAG_BIT = 17;
  localparam int BF_LSB = 15;
  localparam int Z_MSB = 16;
  localparam int CHAR_SEL_LSB = 0;
  localparam int CHAR_WORD_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Function codes
  localparam logic [5:0] OP_HALT = 6'h00;
  localparam logic [5:0] OP_UJMP = 6'h01;
  localparam logic [5:0] OP_IJMP = 6'h02;
  localparam logic [5:0] OP_CJMP = 6'h03;
  localparam logic [5:0] OP_SKEQ = 6'h04;
  localparam logic [5:0] OP_SKGE = 6'h05;
  localparam logic [5:0] OP_SRCH_EQ = 6'h06;
  localparam logic [5:0] OP_SRCH_GE = 6'h07;
  localparam logic [5:0] OP_STEP = 6'h08;
  localparam logic [5:0] OP_ENTZ = 6'h09;
  localparam logic [5:0] OP_SHS = 6'h0A;
  localparam logic [5:0] OP_SHD = 6'h0B;
  localparam logic [5:0] OP_ENT = 6'h0C;
  localparam logic [5:0] OP_INC = 6'h0D;
  localparam logic [5:0] OP_XOR = 6'h0E;
  localparam logic [5:0] OP_AND = 6'h0F;
  localparam logic [5:0] OP_LD_A = 6'h10;
  localparam logic [5:0] OP_LD_Q = 6'h11;
  localparam logic [5:0] OP_LCH_A = 6'h12;
  localparam logic [5:0] OP_LCH_Q = 6'h13;
  localparam logic [5:0] OP_LDC_A = 6'h14;
  localparam logic [5:0] OP_LD_AQ = 6'h15;
  localparam logic [5:0] OP_LDC_AQ = 6'h16;
  localparam logic [5:0] OP_LD_AND = 6'h17;
  localparam logic [5:0] OP_ADD_A = 6'h18;
  localparam logic [5:0] OP_SUB_A = 6'h19;
  localparam logic [5:0] OP_ADD_AQ = 6'h1A;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-codes
  localparam logic [2:0] SEL_HALT = 3'h0;
  localparam logic [2:0] SEL_RET = 3'h7;
  localparam logic [1:0] CND_EQ = 2'h0;
  localparam logic [1:0] CND_NE = 2'h1;
  localparam logic [1:0] CND_GE = 2'h2;
  localparam logic [1:0] TGT_A = 2'h0;
  localparam logic [1:0] TGT_Q = 2'h1;
  localparam logic [1:0] TGT_AQ = 2'h2;
  localparam logic [1:0] SRCH_IDX_EQ = 2'h1;
  localparam logic [1:0] SRCH_IDX_TH = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [14:0] P_RESET = 15'h0000;
  localparam logic [5:0] SCALE_MAX = 6'h2F;

  typedef enum logic [3:0] {
    ST_IDLE, ST_IND, ST_EXEC, ST_RD1, ST_RD2, ST_SRCH, ST_SCMP, ST_SHIFT, ST_SCALE, ST_HALT
  } bie_st_t;

endpackage : bie_pkg

// *** src/bie_exec.sv ***
// Execute unit for basic function codes 00 to 32 with A, Q, index and P.
// Assumes storage answers mem_rdata combinationally while mem_rd is high.
//
// Operation
// RULE1 - Top bit is sign; widen by copying it
// RULE2 - Store overwrites location, source register kept intact
// RULE3 - Halt stops; restart resumes at address m
// RULE4 - Jump key test 1-6 jumps to m if set
// RULE5 - Return jump writes P+1 at m, runs m+1
// RULE6 - Unconditional jump to indexed, indirect effective address
// RULE7 - Index jump: zero continues, else step, jump
// RULE8 - Compare A with zero or Q, jump
// RULE9 - Skip if immediate equals selected register
// RULE10 - Skip if selected register not less than immediate
// RULE11 - Masked search steps index, compares, repeats
// RULE12 - Storage sign test, rotate left, write back
// RULE13 - Index step: equal clears and skips, else step
// RULE14 - Enter 17-bit immediate into A
// RULE15 - Shift count k plus index, sign picks direction
// RULE16 - Left shifts rotate, right shifts drop bits
// RULE17 - Scale rotates until top A bits differ
// RULE18 - Enter immediate into register, empty sub-code nop
// RULE19 - Increase register by immediate
// RULE20 - XOR or AND immediate into register
// RULE21 - Word, character, complement, pair and masked loads
// RULE22 - Add, subtract, double add from storage
// RULE23 - Six-bit function field selects operation
// RULE24 - Program address wraps one's complement modulo 2^15-1
// RULE25 - End-around carry arithmetic, 24 and 48 bits
`timescale 1ns/1ps
module bie_exec #(
  parameter int unsigned SCALE_LIMIT = 47
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [23:0] instr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [5:0] jump_keys,
  input wire logic restart,
  output logic mem_rd,
  output logic mem_wr,
  output logic [14:0] mem_addr,
  output logic [23:0] mem_wdata,
  input wire logic [23:0] mem_rdata,
  output logic [14:0] p_addr,
  output logic [23:0] acc,
  output logic [23:0] aux,
  output logic halted
);

  if (SCALE_LIMIT > 47 || SCALE_LIMIT < 1) begin : g_chk
    $error("SCALE_LIMIT out of range");
  end

  typedef struct packed {
    bie_pkg::bie_st_t st;
    logic [14:0] p;
    logic [23:0] a;
    logic [23:0] q;
    logic [3:1][14:0] bx;
    logic [23:0] ir;
    logic [14:0] ea;
    logic [23:0] tmp;
    logic [5:0] cnt;
    logic [1:0] tgt;
    logic sdir;
    logic mrd;
    logic mwr;
    logic [14:0] maddr;
    logic [23:0] mwdata;
    logic [6:0] ks1;
    logic [6:0] ks2;
    logic [6:0] ks3;
    logic [6:0] kv;
    logic kp;
  } bie_core_t;

  bie_core_t s_r;
  bie_core_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // One's complement helpers
  function automatic logic [23:0] oadd24(input logic [23:0] x, input logic [23:0] y);
    logic [24:0] t;
    t = {1'b0, x} + {1'b0, y};
    return t[23:0] + {23'h000000, t[24]}; // [RULE25]
  endfunction : oadd24

  function automatic logic [14:0] oadd15(input logic [14:0] x, input logic [14:0] y);
    logic [15:0] t;
    t = {1'b0, x} + {1'b0, y};
    return t[14:0] + {14'h0000, t[15]}; // [RULE24]
  endfunction : oadd15

  function automatic logic [47:0] oadd48(input logic [47:0] x, input logic [47:0] y);
    logic [48:0] t;
    t = {1'b0, x} + {1'b0, y};
    return t[47:0] + {47'h0, t[48]}; // [RULE25]
  endfunction : oadd48

  function automatic logic eq24(input logic [23:0] x, input logic [23:0] y);
    return &oadd24(x, ~y);
  endfunction : eq24

  function automatic logic ge24(input logic [23:0] x, input logic [23:0] y);
    logic [23:0] d;
    d = oadd24(x, ~y);
    return (&d) || !d[23];
  endfunction : ge24

  function automatic logic [23:0] sext15(input logic [14:0] v);
    return {{9{v[14]}}, v}; // [RULE1]
  endfunction : sext15

  ////////////////////////////////////////////////////////////////////////////
  // Fields of the held and incoming instructions, and values derived from them
  logic [5:0] op;
  logic aflag;
  logic [1:0] bfld;
  logic [2:0] sel;
  logic [14:0] mf;
  logic [14:0] bval;
  logic [14:0] p1;
  logic [14:0] p2;
  logic [23:0] yv;
  logic [23:0] opnd;
  logic [23:0] kk;
  logic [23:0] dres;
  logic [14:0] ires;
  logic [5:0] d_op;
  logic [1:0] d_bf;
  logic [14:0] d_bval;
  logic d_mem;
  logic [1:0] sidx;
  logic [14:0] sval;
  logic [14:0] snew;
  logic [23:0] mask;
  logic [5:0] chr;
  logic [23:0] cv;
  logic hit;

  assign op = s_r.ir[23:bie_pkg::OP_LSB]; // [RULE23]
  assign aflag = s_r.ir[bie_pkg::AFLAG_BIT];
  assign bfld = s_r.ir[16:bie_pkg::BF_LSB];
  assign sel = s_r.ir[bie_pkg::AFLAG_BIT:bie_pkg::BF_LSB];
  assign mf = s_r.ir[14:0];
  assign bval = (bfld == 2'h0) ? 15'h0000 : s_r.bx[bfld];
  assign p1 = oadd15(s_r.p, 15'h0001); // [RULE24]
  assign p2 = oadd15(s_r.p, 15'h0002); // [RULE24]
  assign yv = bfld[1] ? sext15(mf) : {9'h000, mf}; // [RULE1]
  assign opnd = bfld[0] ? s_r.q : s_r.a;
  assign kk = oadd24(sext15(mf), sext15(bval)); // [RULE15]
  assign d_op = instr[23:bie_pkg::OP_LSB];
  assign d_bf = instr[16:bie_pkg::BF_LSB];
  assign d_bval = (d_bf == 2'h0) ? 15'h0000 : s_r.bx[d_bf];
  assign d_mem = (d_op == bie_pkg::OP_UJMP) || ((d_op >= bie_pkg::OP_LD_A) &&
                 (d_op <= bie_pkg::OP_ADD_AQ) && (d_op != bie_pkg::OP_LCH_A) &&
                 (d_op != bie_pkg::OP_LCH_Q));
  assign sidx = (op == bie_pkg::OP_SRCH_EQ) ? bie_pkg::SRCH_IDX_EQ : bie_pkg::SRCH_IDX_TH;
  assign sval = s_r.bx[sidx];
  assign snew = oadd15(sval, ~{12'h000, sel}); // [RULE11]
  assign mask = s_r.q & mem_rdata;
  assign chr = mem_rdata[23 - 6 * s_r.ir[1:0] -: bie_pkg::CHAR_W]; // [RULE21]

  // Immediate results for codes 14 to 17
  always_comb begin
    case (op)
      bie_pkg::OP_ENT: begin
        dres = yv; // [RULE18]
        ires = mf;
      end
      bie_pkg::OP_INC: begin
        dres = oadd24(opnd, yv); // [RULE19]
        ires = oadd15(bval, mf);
      end
      bie_pkg::OP_XOR: begin
        dres = opnd ^ yv; // [RULE20]
        ires = bval ^ mf;
      end
      default: begin
        dres = opnd & yv; // [RULE20]
        ires = bval & mf;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    cv = 24'h000000;
    hit = 1'b0;
    s_nxt.mrd = 1'b0;
    s_nxt.mwr = 1'b0;
    s_nxt.ks1 = {restart, jump_keys};
    s_nxt.ks2 = s_r.ks1;
    s_nxt.ks3 = s_r.ks2;
    if (s_r.ks2 == s_r.ks3) begin
      s_nxt.kv = s_r.ks3;
    end
    s_nxt.kp = s_r.kv[6];
    case (s_r.st)
      bie_pkg::ST_IDLE: begin
        if (instr_valid) begin
          s_nxt.ir = instr;
          if (d_op == bie_pkg::OP_LCH_A || d_op == bie_pkg::OP_LCH_Q) begin
            s_nxt.ea = instr[16:bie_pkg::CHAR_WORD_LSB];
          end else if (d_mem) begin
            s_nxt.ea = oadd15(instr[14:0], d_bval); // [RULE6]
          end else begin
            s_nxt.ea = instr[14:0];
          end
          if (d_mem && instr[bie_pkg::AFLAG_BIT]) begin
            s_nxt.mrd = 1'b1;
            s_nxt.maddr = oadd15(instr[14:0], d_bval);
            s_nxt.st = bie_pkg::ST_IND; // [RULE6]
          end else begin
            s_nxt.st = bie_pkg::ST_EXEC;
          end
        end
      end
      bie_pkg::ST_IND: begin
        s_nxt.ea = mem_rdata[14:0]; // [RULE6]
        s_nxt.st = bie_pkg::ST_EXEC;
      end
      bie_pkg::ST_EXEC: begin
        s_nxt.st = bie_pkg::ST_IDLE;
        s_nxt.p = p1;
        case (op)
          bie_pkg::OP_HALT: begin
            if (sel == bie_pkg::SEL_HALT) begin
              s_nxt.st = bie_pkg::ST_HALT; // [RULE3]
            end else if (sel == bie_pkg::SEL_RET) begin
              s_nxt.p = s_r.p; // [RULE5]
              s_nxt.mrd = 1'b1;
              s_nxt.maddr = mf;
              s_nxt.st = bie_pkg::ST_RD1;
            end else if (s_r.kv[sel - 3'h1]) begin
              s_nxt.p = mf; // [RULE4]
            end
          end
          bie_pkg::OP_UJMP: s_nxt.p = s_r.ea; // [RULE6]
          bie_pkg::OP_IJMP: begin
            if (bfld != 2'h0 && !(bval == 15'h0000 || bval == 15'h7FFF)) begin
              s_nxt.bx[bfld] = oadd15(bval, aflag ? 15'h7FFE : 15'h0001); // [RULE7]
              s_nxt.p = mf;
            end
          end
          bie_pkg::OP_CJMP: begin
            cv = aflag ? s_r.q : 24'h000000;
            case (bfld)
              bie_pkg::CND_EQ: hit = eq24(s_r.a, cv);
              bie_pkg::CND_NE: hit = !eq24(s_r.a, cv);
              bie_pkg::CND_GE: hit = ge24(s_r.a, cv);
              default: hit = !ge24(s_r.a, cv);
            endcase
            if (hit) begin
              s_nxt.p = mf; // [RULE8]
            end
          end
          bie_pkg::OP_SKEQ: begin
            if (aflag ? (bfld[1] ? eq24(opnd, yv) : (opnd[14:0] == mf)) : (bval == mf)) begin
              s_nxt.p = p2; // [RULE9]
            end
          end
          bie_pkg::OP_SKGE: begin
            if (aflag ? ge24(opnd, yv) : ge24(sext15(bval), sext15(mf))) begin
              s_nxt.p = p2; // [RULE10]
            end
          end
          bie_pkg::OP_SRCH_EQ, bie_pkg::OP_SRCH_GE: begin
            s_nxt.p = s_r.p;
            s_nxt.st = bie_pkg::ST_SRCH; // [RULE11]
          end
          bie_pkg::OP_STEP: begin
            if (bfld == 2'h0) begin
              s_nxt.p = s_r.p; // [RULE12]
              s_nxt.mrd = 1'b1;
              s_nxt.maddr = mf;
              s_nxt.st = bie_pkg::ST_RD1; // [RULE12]
            end else if (bval == mf) begin
              s_nxt.bx[bfld] = 15'h0000; // [RULE13]
              s_nxt.p = p2;
            end else begin
              s_nxt.bx[bfld] = oadd15(bval, aflag ? 15'h7FFE : 15'h0001); // [RULE13]
            end
          end
          bie_pkg::OP_ENTZ: begin
            s_nxt.a = aflag ? {{7{s_r.ir[bie_pkg::Z_MSB]}}, s_r.ir[16:0]}
                            : {7'h00, s_r.ir[16:0]}; // [RULE14]
          end
          bie_pkg::OP_SHS, bie_pkg::OP_SHD: begin
            s_nxt.p = s_r.p;
            s_nxt.sdir = kk[23];
            s_nxt.cnt = kk[23] ? ~kk[5:0] : kk[5:0]; // [RULE15]
            if (op == bie_pkg::OP_SHS) begin
              s_nxt.tgt = aflag ? bie_pkg::TGT_Q : bie_pkg::TGT_A;
              s_nxt.st = bie_pkg::ST_SHIFT;
            end else if (!aflag) begin
              s_nxt.tgt = bie_pkg::TGT_AQ;
              s_nxt.st = bie_pkg::ST_SHIFT;
            end else begin
              s_nxt.cnt = 6'h00;
              s_nxt.st = bie_pkg::ST_SCALE;
            end
          end
          bie_pkg::OP_ENT, bie_pkg::OP_INC, bie_pkg::OP_XOR, bie_pkg::OP_AND: begin
            if (aflag && bfld[0]) begin
              s_nxt.q = dres; // [RULE18]
            end else if (aflag) begin
              s_nxt.a = dres;
            end else if (bfld != 2'h0) begin
              s_nxt.bx[bfld] = ires; // [RULE19]
            end
          end
          default: begin
            if (op >= bie_pkg::OP_LD_A && op <= bie_pkg::OP_ADD_AQ) begin
              s_nxt.p = s_r.p;
              s_nxt.mrd = 1'b1;
              s_nxt.maddr = s_r.ea;
              s_nxt.st = bie_pkg::ST_RD1; // [RULE21]
            end
          end
        endcase
      end
      bie_pkg::ST_RD1: begin
        s_nxt.st = bie_pkg::ST_IDLE;
        s_nxt.p = p1;
        case (op)
          bie_pkg::OP_HALT: begin
            s_nxt.mwr = 1'b1;
            s_nxt.maddr = mf;
            s_nxt.mwdata = {mem_rdata[23:15], p1}; // [RULE5]
            s_nxt.p = oadd15(mf, 15'h0001); // [RULE5]
          end
          bie_pkg::OP_STEP: begin
            s_nxt.mwr = 1'b1;
            s_nxt.maddr = mf;
            s_nxt.mwdata = {mem_rdata[22:0], mem_rdata[23]}; // [RULE2]
            s_nxt.p = mem_rdata[23] ? p2 : p1; // [RULE12]
          end
          bie_pkg::OP_LD_A: s_nxt.a = mem_rdata; // [RULE21]
          bie_pkg::OP_LD_Q: s_nxt.q = mem_rdata;
          bie_pkg::OP_LCH_A: s_nxt.a = {18'h00000, chr};
          bie_pkg::OP_LCH_Q: s_nxt.q = {18'h00000, chr};
          bie_pkg::OP_LDC_A: s_nxt.a = ~mem_rdata;
          bie_pkg::OP_LD_AND: s_nxt.a = mask; // [RULE21]
          bie_pkg::OP_ADD_A: s_nxt.a = oadd24(s_r.a, mem_rdata); // [RULE22]
          bie_pkg::OP_SUB_A: s_nxt.a = oadd24(s_r.a, ~mem_rdata); // [RULE22]
          default: begin
            s_nxt.p = s_r.p;
            s_nxt.tmp = mem_rdata;
            s_nxt.mrd = 1'b1;
            s_nxt.maddr = oadd15(s_r.ea, 15'h0001);
            s_nxt.st = bie_pkg::ST_RD2;
          end
        endcase
      end
      bie_pkg::ST_RD2: begin
        s_nxt.st = bie_pkg::ST_IDLE;
        s_nxt.p = p1;
        if (op == bie_pkg::OP_LD_AQ) begin
          s_nxt.a = s_r.tmp; // [RULE21]
          s_nxt.q = mem_rdata;
        end else if (op == bie_pkg::OP_LDC_AQ) begin
          s_nxt.a = ~s_r.tmp;
          s_nxt.q = ~mem_rdata;
        end else begin
          {s_nxt.a, s_nxt.q} = oadd48({s_r.a, s_r.q}, {s_r.tmp, mem_rdata}); // [RULE22]
        end
      end
      bie_pkg::ST_SRCH: begin
        s_nxt.bx[sidx] = snew; // [RULE11]
        if (snew[14]) begin
          s_nxt.p = p1;
          s_nxt.st = bie_pkg::ST_IDLE;
        end else begin
          s_nxt.mrd = 1'b1;
          s_nxt.maddr = oadd15(mf, snew);
          s_nxt.st = bie_pkg::ST_SCMP;
        end
      end
      bie_pkg::ST_SCMP: begin
        if (op == bie_pkg::OP_SRCH_EQ ? eq24(s_r.a, mask) : ge24(s_r.a, mask)) begin
          s_nxt.p = p2; // [RULE11]
          s_nxt.st = bie_pkg::ST_IDLE;
        end else begin
          s_nxt.st = bie_pkg::ST_SRCH;
        end
      end
      bie_pkg::ST_SHIFT: begin
        if (s_r.cnt == 6'h00) begin
          s_nxt.p = p1;
          s_nxt.st = bie_pkg::ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
          if (s_r.tgt == bie_pkg::TGT_AQ) begin
            {s_nxt.a, s_nxt.q} = s_r.sdir ? {s_r.a[23], s_r.a, s_r.q[23:1]}
                                           : {s_r.a[22:0], s_r.q, s_r.a[23]}; // [RULE16]
          end else if (s_r.tgt == bie_pkg::TGT_Q) begin
            s_nxt.q = s_r.sdir ? {s_r.q[23], s_r.q[23:1]} : {s_r.q[22:0], s_r.q[23]};
          end else begin
            s_nxt.a = s_r.sdir ? {s_r.a[23], s_r.a[23:1]} : {s_r.a[22:0], s_r.a[23]};
          end
        end
      end
      bie_pkg::ST_SCALE: begin
        if (s_r.a[23] != s_r.a[22] || s_r.cnt == 6'(SCALE_LIMIT)) begin
          if (bfld != 2'h0) begin
            s_nxt.bx[bfld] = oadd15(mf, ~{9'h000, s_r.cnt}); // [RULE17]
          end
          s_nxt.p = p1;
          s_nxt.st = bie_pkg::ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + 6'h01;
          {s_nxt.a, s_nxt.q} = {s_r.a[22:0], s_r.q, s_r.a[23]}; // [RULE17]
        end
      end
      bie_pkg::ST_HALT: begin
        if (s_r.kv[6] && !s_r.kp) begin
          s_nxt.p = mf; // [RULE3]
          s_nxt.st = bie_pkg::ST_IDLE;
        end
      end
      default: s_nxt.st = bie_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
      s_r.p <= bie_pkg::P_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign instr_ready = (s_r.st == bie_pkg::ST_IDLE);
  assign halted = (s_r.st == bie_pkg::ST_HALT);
  assign mem_rd = s_r.mrd;
  assign mem_wr = s_r.mwr;
  assign mem_addr = s_r.maddr;
  assign mem_wdata = s_r.mwdata;
  assign p_addr = s_r.p;
  assign acc = s_r.a;
  assign aux = s_r.q;

endmodule : bie_exec

// *** bench/bie_exec_properties.sv ***
// Port-level checks for the execute unit.
// Assumes it is bound to bie_exec and sees only that module's ports.
`timescale 1ns/1ps
module bie_exec_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [23:0] instr,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [5:0] jump_keys,
  input wire logic restart,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [14:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  input wire logic [23:0] mem_rdata,
  input wire logic [14:0] p_addr,
  input wire logic [23:0] acc,
  input wire logic [23:0] aux,
  input wire logic halted
);
  logic take;
  logic [14:0] m_r;

  assign take = instr_valid && instr_ready;

  always_ff @(posedge mclk) begin
    if (take) begin
      m_r <= instr[14:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_take_drops_ready: assert property (take |=> !instr_ready)
    else $error("ready stayed high after take");
  chk_halt_not_ready: assert property (halted |-> !instr_ready)
    else $error("ready high while halted");
  chk_halt_entry: assert property (take && instr[23:15] == 9'h000 |-> ##[1:3] halted)
    else $error("halt not entered");
  chk_no_rd_wr: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  chk_undef_nop: assert property (take && instr[23:18] > 6'h1A && p_addr < 15'h7FFE
    |=> !mem_rd && !mem_wr ##1 instr_ready && p_addr == $past(p_addr, 2) + 15'h0001)
    else $error("undefined code not a no-op");
  chk_jump_target: assert property (take && instr[23:15] == {bie_pkg::OP_UJMP, 3'h0}
    |-> ##[2:4] instr_ready && p_addr == m_r)
    else $error("jump target wrong");
  chk_ret_write: assert property (take &&
    instr[23:15] == {bie_pkg::OP_HALT, bie_pkg::SEL_RET} |-> ##[1:4] mem_wr && mem_addr == m_r)
    else $error("return jump write missing");
  chk_load_read: assert property (take && instr[23:15] == {bie_pkg::OP_LD_A, 3'h0}
    |=> ##1 mem_rd && mem_addr == m_r)
    else $error("load read cycle wrong");
  chk_load_value: assert property (take && instr[23:15] == {bie_pkg::OP_LD_A, 3'h0}
    |=> ##2 instr_ready && acc == $past(mem_rdata))
    else $error("load value wrong");
endmodule : bie_exec_properties

// *** bench/bie_exec_tb.sv ***
// Self-checking bench for the execute unit with a small word store.
// Assumes the package, the design and the properties file compile first.
`timescale 1ns/1ps
module bie_exec_tb;
  logic mclk, rst, instr_valid, instr_ready, restart, mem_rd, mem_wr, halted, pend;
  logic [23:0] instr, mem_rdata, mem_wdata, acc, aux, ea, eq, v;
  logic [14:0] mem_addr, p_addr, ep, pr;
  logic [5:0] jump_keys;
  logic [48:0] s48;
  logic [23:0] mem [0:63];
  logic [62:0] notes[$];
  int errors, n_compared;

  bie_exec bie_exec_inst (.mclk, .rst, .instr, .instr_valid, .instr_ready, .jump_keys,
    .restart, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .p_addr, .acc, .aux,
    .halted);

  assign mem_rdata = mem_rd ? mem[mem_addr[5:0]] : ~mem[mem_addr[5:0]];

  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [62:0] seen, input logic [62:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  function automatic logic [14:0] pp(input int d);
    logic [15:0] s;
    s = {1'b0, ep} + 16'(d);
    return s[14:0] + 15'(s[15]);
  endfunction : pp

  function automatic logic [23:0] oc(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[23:0] + 24'(s[24]);
  endfunction : oc

  function automatic logic [23:0] ins(input logic [5:0] o, input logic [2:0] f,
    input logic [14:0] m);
    return {o, f, m};
  endfunction : ins

  // Store writes and completion watcher
  always @(posedge mclk) begin
    if (mem_wr) begin
      mem[mem_addr[5:0]] <= mem_wdata;
    end
    if (pend && instr_ready === 1'b1) begin
      pend = 0;
      check({acc, aux, p_addr}, notes.pop_front());
    end
    if (instr_valid && instr_ready === 1'b1) begin
      pend = 1;
    end
  end

  task automatic op(input logic [23:0] w, input logic [23:0] a, input logic [23:0] q,
    input logic [14:0] p);
    int i;
    @(posedge mclk);
    #1;
    instr = w;
    instr_valid = 1;
    notes.push_back({a, q, p});
    ea = a;
    eq = q;
    ep = p;
    for (i = 0; i < 500 && instr_ready !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 500) begin
      errors++;
      end_sim();
    end
    @(posedge mclk);
    #1;
    instr_valid = 0;
    instr = 24'($urandom);
  endtask : op

  task automatic drain;
    int i;
    for (i = 0; i < 500 && notes.size() != 0; i++) begin
      @(posedge mclk);
    end
    #1;
    if (i == 500) begin
      errors++;
      end_sim();
    end
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    rst = 1;
    instr_valid = 0;
    instr = 0;
    restart = 0;
    jump_keys = 0;
    pend = 0;
    errors = 0;
    n_compared = 0;
    ea = 0;
    eq = 0;
    ep = 0;
    void'($urandom(32'h44f9589e));
    for (k = 0; k < 64; k++) begin
      mem[k] = $urandom;
    end
    repeat (5) @(posedge mclk);
    #1;
    rst = 0;
    // Immediate forms
    v = 24'(14'($urandom)) | 24'h10;
    op(ins(bie_pkg::OP_ENT, 3'h4, v[14:0]), v, eq, pp(1));
    op(ins(bie_pkg::OP_ENT, 3'h7, 15'h4001), ea, 24'hFFC001, pp(1));
    op(ins(bie_pkg::OP_INC, 3'h6, 15'h7FFE), oc(ea, 24'hFFFFFE), eq, pp(1));
    op(ins(bie_pkg::OP_XOR, 3'h7, 15'h4000), ea, eq ^ 24'hFFC000, pp(1));
    op(ins(bie_pkg::OP_AND, 3'h6, 15'h7F0F), ea & 24'hFFFF0F, eq, pp(1));
    op(ins(bie_pkg::OP_ENTZ, 3'h3, 15'h0005), 24'h018005, eq, pp(1));
    op(ins(bie_pkg::OP_ENTZ, 3'h7, 15'h0005), 24'hFF8005, eq, pp(1));
    // Loads and arithmetic
    op(ins(bie_pkg::OP_LD_A, 3'h0, 15'd10), mem[10], eq, pp(1));
    op(ins(bie_pkg::OP_LD_Q, 3'h0, 15'd11), ea, mem[11], pp(1));
    op(ins(bie_pkg::OP_LDC_A, 3'h0, 15'd12), ~mem[12], eq, pp(1));
    op(ins(bie_pkg::OP_LD_AND, 3'h0, 15'd15), mem[15] & eq, eq, pp(1));
    op(ins(bie_pkg::OP_LCH_A, 3'h0, 15'h41), {18'h0, mem[16][17:12]}, eq, pp(1));
    op(ins(bie_pkg::OP_LDC_AQ, 3'h0, 15'd13), ~mem[13], ~mem[14], pp(1));
    op(ins(bie_pkg::OP_ADD_A, 3'h0, 15'd17), oc(ea, mem[17]), eq, pp(1));
    op(ins(bie_pkg::OP_SUB_A, 3'h0, 15'd18), oc(ea, ~mem[18]), eq, pp(1));
    s48 = {1'b0, ea, eq} + {1'b0, mem[19], mem[20]};
    s48 = {1'b0, s48[47:0]} + 49'(s48[48]);
    op(ins(bie_pkg::OP_ADD_AQ, 3'h0, 15'd19), s48[47:24], s48[23:0], pp(1));
    // Shifts and scale
    op(ins(bie_pkg::OP_SHS, 3'h0, 15'd3), {ea[20:0], ea[23:21]}, eq, pp(1));
    op(ins(bie_pkg::OP_SHS, 3'h4, 15'h7FFD), ea, 24'($signed(eq) >>> 2), pp(1));
    op(ins(bie_pkg::OP_ENT, 3'h2, 15'd2), ea, eq, pp(1));
    s48 = {1'b0, ea[20:0], eq, ea[23:21]};
    op(ins(bie_pkg::OP_SHD, 3'h2, 15'd1), s48[47:24], s48[23:0], pp(1));
    op(ins(bie_pkg::OP_ENT, 3'h4, 15'd1), 24'h1, eq, pp(1));
    op(ins(bie_pkg::OP_ENT, 3'h5, 15'd0), ea, 24'h0, pp(1));
    op(ins(bie_pkg::OP_SHD, 3'h4, 15'd0), 24'h400000, eq, pp(1));
    // Jumps and skips
    op(ins(bie_pkg::OP_UJMP, 3'h0, 15'd40), ea, eq, 15'd40);
    op(ins(bie_pkg::OP_CJMP, 3'h1, 15'd30), ea, eq, 15'd30);
    op(ins(bie_pkg::OP_CJMP, 3'h7, 15'd50), ea, eq, pp(1));
    op(ins(bie_pkg::OP_CJMP, 3'h6, 15'd50), ea, eq, 15'd50);
    op(ins(bie_pkg::OP_SKEQ, 3'h6, 15'd0), ea, eq, pp(1));
    op(ins(bie_pkg::OP_SKEQ, 3'h4, 15'd0), ea, eq, pp(2));
    op(ins(bie_pkg::OP_SKGE, 3'h6, 15'h7000), ea, eq, pp(2));
    op(ins(bie_pkg::OP_SKGE, 3'h5, 15'd1), ea, eq, pp(1));
    op(ins(bie_pkg::OP_ENT, 3'h1, 15'd2), ea, eq, pp(1));
    for (k = 0; k < 3; k++) begin
      op(ins(bie_pkg::OP_IJMP, 3'h5, 15'd20), ea, eq, k < 2 ? 15'd20 : pp(1));
    end
    op(ins(bie_pkg::OP_STEP, 3'h3, 15'd1), ea, eq, pp(1));
    op(ins(bie_pkg::OP_STEP, 3'h3, 15'd1), ea, eq, pp(2));
    // Masked searches: no match runs out, threshold hits first probe
    op(ins(bie_pkg::OP_ENT, 3'h1, 15'd3), ea, eq, pp(1));
    op(ins(bie_pkg::OP_SRCH_EQ, 3'h1, 15'd24), ea, eq, pp(1));
    op(ins(bie_pkg::OP_SRCH_GE, 3'h1, 15'd24), ea, eq, pp(2));
    // Storage rotate and return jump
    mem[21] = 24'h800001;
    op(ins(bie_pkg::OP_STEP, 3'h0, 15'd21), ea, eq, pp(2));
    v = mem[22];
    pr = pp(1);
    op(ins(bie_pkg::OP_HALT, 3'h7, 15'd22), ea, eq, 15'd23);
    drain();
    check(63'(mem[21]), 63'h3);
    check(63'(mem[22]), 63'({v[23:15], pr}));
    // Console keys, undefined codes, wrap
    jump_keys = 6'h04;
    repeat (6) @(posedge mclk);
    for (k = 0; k < 6; k++) begin
      op(ins(bie_pkg::OP_HALT, 3'(k + 1), 15'd33), ea, eq, k == 2 ? 15'd33 : pp(1));
    end
    op(ins(6'h1B, 3'h0, 15'd0), ea, eq, pp(1));
    op(ins(bie_pkg::OP_UJMP, 3'h0, 15'h7FFF), ea, eq, 15'h7FFF);
    op(ins(6'h3F, 3'h0, 15'd0), ea, eq, 15'h0001);
    // Halt and restart
    op(ins(bie_pkg::OP_HALT, 3'h0, 15'd44), ea, eq, 15'd44);
    repeat (4) @(posedge mclk);
    #1;
    check(63'(halted), 63'h1);
    restart = 1;
    repeat (6) @(posedge mclk);
    #1;
    restart = 0;
    drain();
    check(63'(halted), 63'h0);
    end_sim();
  end
endmodule : bie_exec_tb

bind bie_exec bie_exec_properties bie_exec_properties_inst (.mclk, .rst, .instr,
  .instr_valid, .instr_ready, .jump_keys, .restart, .mem_rd, .mem_wr, .mem_addr,
  .mem_wdata, .mem_rdata, .p_addr, .acc, .aux, .halted);
